// File: include/awtsc_pkg.sv
// Purpose: Shared constants for the converter window, trigger and scan control.
// Assumes: 32-bit APB data, one aligned word per register, 8-bit byte address.
// Notes:   Offsets are byte addresses; field positions are bit indices.
package awtsc_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] OFS_CONTROL = 8'h04;
	localparam logic [7:0] OFS_WIN_CTRL = 8'h08;
	localparam logic [7:0] OFS_SW_TRIG = 8'h0C;
	localparam logic [7:0] OFS_INPUT = 8'h10;
	localparam logic [7:0] OFS_WIN_LOWER = 8'h18;
	localparam logic [7:0] OFS_WIN_UPPER = 8'h1C;
	localparam logic [7:0] OFS_RESULT = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	// ==========================================================
	// Field positions
	localparam int CTL_DIFF_BIT = 0;
	localparam int CTL_LEFT_BIT = 1;
	localparam int CTL_CONT_BIT = 2;
	localparam int CTL_WEO_BIT = 3;
	localparam int SWT_FLUSH_BIT = 0;
	localparam int SWT_START_BIT = 1;
	localparam int INP_POS_LSB = 0;
	localparam int INP_NEG_LSB = 8;
	localparam int INP_SCAN_LSB = 16;
	localparam int INP_OFFS_LSB = 20;
	localparam int INP_GAIN_LSB = 24;
	localparam int STAT_WINMON_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_SYNC_BIT = 2;
	// ==========================================================
	// Reset values
	localparam logic [3:0] RST_CONTROL = 4'h0;
	localparam logic [2:0] RST_WIN_MODE = 3'h0;
	localparam logic [31:0] RST_INPUT = 32'h00000000;
	localparam logic [15:0] RST_THRESH = 16'h0000;
	// ==========================================================
	// Encodings and timing
	localparam logic [2:0] WIN_OFF = 3'h0;
	localparam logic [2:0] WIN_ABOVE_LOWER = 3'h1;
	localparam logic [2:0] WIN_BELOW_UPPER = 3'h2;
	localparam logic [2:0] WIN_INSIDE = 3'h3;
	localparam logic [2:0] WIN_OUTSIDE = 3'h4;
	localparam logic [3:0] GAIN_X16 = 4'h4;
	localparam logic [3:0] GAIN_HALF = 4'hF;
	localparam logic [3:0] GAIN_X1 = 4'h0;
	localparam logic [4:0] NEG_PIN_MAX = 5'h07;
	localparam logic [4:0] NEG_INT_GND = 5'h18;
	localparam logic [4:0] NEG_IO_GND = 5'h19;
	localparam int CONV_CLK_DIV = 4;
	localparam int RES_W = 12;

	// Reserved gain codes fall back to unity gain
	function automatic logic [3:0] legal_gain(input logic [3:0] code);
		legal_gain = (code <= GAIN_X16 || code == GAIN_HALF) ? code : GAIN_X1;
	endfunction

	// Reserved negative codes fall back to internal ground
	function automatic logic [4:0] legal_neg(input logic [4:0] code);
		legal_neg = (code <= NEG_PIN_MAX || code == NEG_IO_GND) ? code : NEG_INT_GND;
	endfunction
endpackage

// File: include/awtsc_res_if.sv
// Purpose: Carries a finished conversion to the result stage and back.
// Assumes: Single clock domain, pclk.
// Notes:   done and hit are registered in the result stage.
`timescale 1ns/1ns
interface awtsc_res_if;
	logic valid;
	logic [11:0] data;
	logic left_align;
	logic [2:0] mode;
	logic [15:0] lower;
	logic [15:0] upper;
	logic [15:0] result;
	logic done;
	logic hit;
	modport src (output valid, data, left_align, mode, lower, upper,
		input result, done, hit);
	modport proc (input valid, data, left_align, mode, lower, upper,
		output result, done, hit);
endinterface

// File: design/awtsc_result_proc.sv
// Purpose: Aligns each new conversion result and runs the window compare.
// Assumes: valid is a one-cycle pulse for a result that was not aborted.
// Notes:   Compare uses the unshifted value so alignment never moves the window.
`timescale 1ns/1ns
module awtsc_result_proc
	import awtsc_pkg::*;
(
	input wire logic pclk, // Peripheral clock
	input wire logic presetn, // Async reset, low
	input wire logic ce, // Clock enable
	awtsc_res_if.proc res // Result carrier
);
	logic [15:0] result_q;
	logic done_q;
	logic hit_q;
	logic [15:0] value;

	// ==========================================================
	// Window decision
	function automatic logic window_hit(input logic [2:0] mode, input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] up);
		unique case (mode)
			WIN_ABOVE_LOWER: window_hit = v > lo;
			WIN_BELOW_UPPER: window_hit = v < up;
			WIN_INSIDE: window_hit = (v > lo) && (v < up);
			WIN_OUTSIDE: window_hit = !((v > lo) && (v < up));
			default: window_hit = 1'b0; // Off and reserved modes
		endcase
	endfunction

	assign value = {4'h0, res.data};

	// Result capture, alignment and compare on every new result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_q <= 16'h0000;
			done_q <= 1'b0;
			hit_q <= 1'b0;
		end else if (ce) begin
			done_q <= res.valid;
			if (res.valid) begin
				result_q <= res.left_align ? {res.data, 4'h0} : value;
				hit_q <= window_hit(res.mode, value, res.lower, res.upper);
			end
		end
	end

	assign res.result = result_q;
	assign res.done = done_q;
	assign res.hit = hit_q;

	// ==========================================================
	// Checks
	property p_align;
		@(posedge pclk) disable iff (!presetn)
		(ce && res.valid) |=> (result_q == ($past(res.left_align) ?
			{$past(res.data), 4'h0} : {4'h0, $past(res.data)}));
	endproperty
	a_align: assert property (p_align) else $error("result alignment wrong");

	property p_mode_off;
		@(posedge pclk) disable iff (!presetn)
		(ce && res.valid && (res.mode == WIN_OFF || res.mode > WIN_OUTSIDE)) |=> !hit_q;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("hit with window off");

	property p_mode1;
		@(posedge pclk) disable iff (!presetn)
		(ce && res.valid && res.mode == WIN_ABOVE_LOWER) |=> (hit_q == ($past(value) > $past(res.lower)));
	endproperty
	a_mode1: assert property (p_mode1) else $error("mode 1 compare wrong");

	property p_mode4;
		@(posedge pclk) disable iff (!presetn)
		(ce && res.valid && res.mode == WIN_OUTSIDE && value > res.lower && value < res.upper)
		|=> !hit_q;
	endproperty
	a_mode4: assert property (p_mode4) else $error("mode 4 hit inside window");
endmodule

// File: design/awtsc_top.sv
// Purpose: Control for a converter: triggers, flush, scan, input select, window.
// Assumes: APB slave on pclk; analog core pulses conv_done with conv_data.
// Notes:   All outputs are flops; ce low freezes every state element.
`timescale 1ns/1ns
module awtsc_top
	import awtsc_pkg::*;
#(
	parameter int unsigned CLK_DIV = CONV_CLK_DIV
) (
	input wire logic pclk, // Peripheral clock
	input wire logic presetn, // Async reset, low
	input wire logic ce, // Clock enable, freezes all
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped
	output logic conv_clk, // Converter clock
	output logic conv_start, // Start pulse to core
	output logic conv_abort, // Abort pulse to core
	output logic [4:0] conv_pos_sel, // Positive input
	output logic [4:0] conv_neg_sel, // Negative input
	output logic conv_diff, // Differential mode
	output logic [3:0] conv_gain, // Gain stage code
	input wire logic conv_done, // Conversion finished
	input wire logic [11:0] conv_data, // Raw result
	output logic win_event // Window event pulse
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01,
		ST_FLUSH = 2'b11
	} awtsc_state_type;

	awtsc_state_type state_q;
	logic [3:0] ctrl_q;
	logic [2:0] win_mode_q;
	logic [15:0] lower_q;
	logic [15:0] upper_q;
	logic [31:0] inp_q;
	logic start_q, flush_q, redo_q, winmon_q;
	logic [3:0] step_q, base_q;
	logic [31:0] div_q;
	logic pready_q, pslverr_q, conv_clk_q, conv_start_q, conv_abort_q;
	logic [31:0] prdata_q;
	logic [4:0] pos_q, neg_q;
	logic diff_q, win_event_q;
	logic [3:0] gain_q;
	logic [31:0] rd_word;
	logic rd_ok;
	logic wr_hit, wr_sw, wr_inp, wr_start, wr_flush, wr_stat;
	logic launch_go, done_ok, scan_on, scan_last;
	logic [3:0] offs, scan_cnt;
	logic [4:0] pos_sum;
	awtsc_res_if res ();

	// ==========================================================
	// Bus decode: a write lands only at the edge pready is seen high
	assign wr_hit = psel && penable && pready_q && pwrite;
	assign wr_sw = wr_hit && paddr == OFS_SW_TRIG;
	assign wr_inp = wr_hit && paddr == OFS_INPUT;
	assign wr_stat = wr_hit && paddr == OFS_STATUS;
	assign wr_start = wr_sw && pwdata[SWT_START_BIT];
	assign wr_flush = wr_sw && pwdata[SWT_FLUSH_BIT]; // Zero write ignored

	// Read mux; unmapped addresses read zero and flag an error
	always_comb begin
		rd_word = 32'h00000000;
		rd_ok = 1'b1;
		case (paddr)
			OFS_CONTROL: rd_word[3:0] = ctrl_q;
			OFS_WIN_CTRL: rd_word[2:0] = win_mode_q;
			OFS_SW_TRIG: rd_word[1:0] = {start_q, flush_q};
			OFS_INPUT: rd_word = inp_q;
			OFS_WIN_LOWER: rd_word[15:0] = lower_q;
			OFS_WIN_UPPER: rd_word[15:0] = upper_q;
			OFS_RESULT: rd_word[15:0] = res.result;
			OFS_STATUS: rd_word[2:0] = {flush_q | start_q, state_q != ST_IDLE, winmon_q};
			default: rd_ok = 1'b0;
		endcase
	end

	// One wait state: ready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else if (ce) begin
			pready_q <= psel && penable && !pready_q;
			if (psel && penable && !pready_q) begin
				pslverr_q <= !rd_ok;
				prdata_q <= pwrite ? 32'h00000000 : rd_word;
			end
		end
	end

	// ==========================================================
	// Plain configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= RST_CONTROL;
			win_mode_q <= RST_WIN_MODE;
			lower_q <= RST_THRESH;
			upper_q <= RST_THRESH;
		end else if (ce && wr_hit) begin
			if (paddr == OFS_CONTROL) ctrl_q <= pwdata[3:0];
			if (paddr == OFS_WIN_CTRL) win_mode_q <= pwdata[2:0]; // Reserved kept, inert
			if (paddr == OFS_WIN_LOWER) lower_q <= pwdata[15:0];
			if (paddr == OFS_WIN_UPPER) upper_q <= pwdata[15:0];
		end
	end

	// ==========================================================
	// Scan bookkeeping
	assign offs = inp_q[INP_OFFS_LSB +: 4];
	assign scan_cnt = inp_q[INP_SCAN_LSB +: 4];
	assign scan_on = scan_cnt != 4'h0;
	assign scan_last = step_q == scan_cnt; // count plus one steps
	assign pos_sum = inp_q[INP_POS_LSB +: 5] + {1'b0, offs};
	assign done_ok = state_q == ST_BUSY && conv_done && !flush_q;
	assign launch_go = state_q == ST_IDLE && !flush_q && (start_q || redo_q);

	// Input control; the offset walks during a scan and wraps to its start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inp_q <= RST_INPUT;
			step_q <= 4'h0;
			base_q <= 4'h0;
		end else if (ce) begin
			if (wr_inp) begin
				inp_q <= pwdata & 32'h0FFF1F1F; // Unused bits read zero
				step_q <= 4'h0;
			end else if (done_ok && scan_on) begin
				if (scan_last) begin
					inp_q[INP_OFFS_LSB +: 4] <= base_q;
					step_q <= 4'h0;
				end else begin
					inp_q[INP_OFFS_LSB +: 4] <= offs + 4'h1;
					step_q <= step_q + 4'h1;
				end
			end
			if (launch_go && step_q == 4'h0) base_q <= offs;
		end
	end

	// ==========================================================
	// Trigger bits; a start rewrite while set is dropped, a flush set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_q <= 1'b0;
			flush_q <= 1'b0;
		end else if (ce) begin
			if (wr_start && !start_q) start_q <= 1'b1; // Set: no second request
			else if (launch_go) start_q <= 1'b0;
			if (wr_flush) flush_q <= 1'b1;
			else if (state_q == ST_FLUSH) flush_q <= 1'b0;
		end
	end

	// Conversion sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			redo_q <= 1'b0;
		end else if (ce) begin
			unique case (state_q)
				ST_IDLE: begin
					if (flush_q) state_q <= ST_FLUSH;
					else if (launch_go) begin
						state_q <= ST_BUSY;
						redo_q <= 1'b0;
					end
				end
				ST_BUSY: begin
					if (flush_q) begin
						state_q <= ST_FLUSH;
						redo_q <= 1'b1; // Aborted work resumes
					end else if (conv_done) begin
						state_q <= ST_IDLE;
						redo_q <= ctrl_q[CTL_CONT_BIT];
					end
				end
				ST_FLUSH: state_q <= ST_IDLE; // Pending start relaunches
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Converter clock divider, restarted by a flush
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 32'h00000000;
			conv_clk_q <= 1'b0;
		end else if (ce) begin
			if (flush_q) begin
				div_q <= 32'h00000000;
				conv_clk_q <= 1'b0;
			end else if (div_q == 32'(CLK_DIV / 2 - 1)) begin
				div_q <= 32'h00000000;
				conv_clk_q <= !conv_clk_q;
			end else begin
				div_q <= div_q + 32'h00000001;
			end
		end
	end

	// Start and abort registered every cycle; input, diff and gain selects latched at launch so a mid-conversion write cannot glitch them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_start_q <= 1'b0;
			conv_abort_q <= 1'b0;
			pos_q <= 5'h00;
			neg_q <= 5'h00;
			diff_q <= 1'b0;
			gain_q <= 4'h0;
		end else if (ce) begin
			conv_start_q <= launch_go;
			conv_abort_q <= state_q != ST_FLUSH && flush_q;
			if (launch_go) begin
				pos_q <= pos_sum;
				neg_q <= legal_neg(inp_q[INP_NEG_LSB +: 5]);
				diff_q <= ctrl_q[CTL_DIFF_BIT];
				gain_q <= legal_gain(inp_q[INP_GAIN_LSB +: 4]);
			end
		end
	end

	// ==========================================================
	// Result stage and window outcome
	assign res.valid = done_ok && ce; // Aborted results never reach here
	assign res.data = conv_data;
	assign res.left_align = ctrl_q[CTL_LEFT_BIT];
	assign res.mode = win_mode_q;
	assign res.lower = lower_q;
	assign res.upper = upper_q;

	awtsc_result_proc u_proc (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.res(res)
	);

	// Sticky monitor flag, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			winmon_q <= 1'b0;
			win_event_q <= 1'b0;
		end else if (ce) begin
			if (res.done && res.hit) winmon_q <= 1'b1;
			else if (wr_stat && pwdata[STAT_WINMON_BIT]) winmon_q <= 1'b0;
			win_event_q <= res.done && res.hit && ctrl_q[CTL_WEO_BIT];
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign conv_clk = conv_clk_q;
	assign conv_start = conv_start_q;
	assign conv_abort = conv_abort_q;
	assign conv_pos_sel = pos_q;
	assign conv_neg_sel = neg_q;
	assign conv_diff = diff_q;
	assign conv_gain = gain_q;
	assign win_event = win_event_q;

	// ==========================================================
	// Checks
	property p_start;
		@(posedge pclk) disable iff (!presetn)
		(launch_go && ce && !wr_start) |=> (conv_start && !start_q);
	endproperty
	a_start: assert property (p_start) else $error("start not launched or kept");

	sequence s_flush_enter;
		ce && flush_q && state_q != ST_FLUSH;
	endsequence
	sequence s_flush_leave;
		ce && state_q == ST_FLUSH && !wr_flush;
	endsequence
	property p_flush;
		@(posedge pclk) disable iff (!presetn)
		s_flush_enter |=> conv_abort && state_q == ST_FLUSH && div_q == 32'h00000000;
	endproperty
	a_flush: assert property (p_flush) else $error("flush did not abort");

	property p_flush_done;
		@(posedge pclk) disable iff (!presetn)
		s_flush_leave |=> !flush_q && state_q == ST_IDLE;
	endproperty
	a_flush_done: assert property (p_flush_done) else $error("flush bit stuck");

	property p_flush_zero;
		@(posedge pclk) disable iff (!presetn)
		(ce && !flush_q && !wr_flush) |=> !flush_q;
	endproperty
	a_flush_zero: assert property (p_flush_zero) else $error("flush set without one");

	property p_scan_step;
		@(posedge pclk) disable iff (!presetn)
		(ce && done_ok && scan_on && !scan_last && !wr_inp) |=> offs == $past(offs) + 4'h1;
	endproperty
	a_scan_step: assert property (p_scan_step) else $error("scan offset not stepped");

	property p_no_scan;
		@(posedge pclk) disable iff (!presetn)
		(ce && done_ok && !scan_on && !wr_inp) |=> $stable(inp_q);
	endproperty
	a_no_scan: assert property (p_no_scan) else $error("offset moved without scan");

	property p_pos;
		@(posedge pclk) disable iff (!presetn)
		(ce && launch_go) |=> conv_pos_sel == $past(pos_sum);
	endproperty
	a_pos: assert property (p_pos) else $error("positive input wrong");

	sequence s_free_done;
		(ce && done_ok && ctrl_q[CTL_CONT_BIT]) ##1 (ce && !flush_q && !wr_flush);
	endsequence
	property p_free;
		@(posedge pclk) disable iff (!presetn)
		s_free_done |=> conv_start;
	endproperty
	a_free: assert property (p_free) else $error("continuous relaunch missing");

	property p_event;
		@(posedge pclk) disable iff (!presetn)
		(ce && res.done) |=> win_event == $past(res.hit && ctrl_q[CTL_WEO_BIT]);
	endproperty
	a_event: assert property (p_event) else $error("window event wrong");
endmodule

// File: verif/awtsc_core_model.sv
// Purpose: Behavioural analog core answering launches with a result.
// Assumes: Latency and value are set by the bench before each launch.
// Notes:   Data line scrambles outside its valid cycle.
`timescale 1ns/1ns
module awtsc_core_model (
	input wire logic pclk, // Peripheral clock
	input wire logic presetn, // Async reset, low
	input wire logic conv_start, // Launch pulse
	input wire logic conv_abort, // Abort pulse
	input wire logic [7:0] lat, // Cycles to result
	input wire logic [11:0] val, // Result to return
	output logic conv_done, // Result strobe
	output logic [11:0] conv_data // Result value
);
	// ==========================================================
	// Conversion timer
	int cnt;
	// Abort drops the running conversion so nothing stale comes back
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			conv_done <= 1'b0;
			conv_data <= 12'hA5A;
		end else begin
			conv_done <= 1'b0;
			conv_data <= ~conv_data;
			if (conv_abort) begin
				cnt <= 0;
			end else if (conv_start) begin
				cnt <= lat;
			end else if (cnt == 1) begin
				conv_done <= 1'b1;
				conv_data <= val;
				cnt <= 0;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule

// File: verif/awtsc_top_test.sv
// Purpose: Self-checking bench for the converter control block.
// Assumes: APB master tasks, behavioural core, CLK_DIV of 2.
// Notes:   ce stays high except in the freeze check; every scenario is its own task.
`timescale 1ns/1ns
module awtsc_top_test;
	import awtsc_pkg::*;
	// ==========================================================
	// Signals
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ce = 1;
	logic [7:0] paddr = 8'h00, lat = 8'h03;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic [11:0] val = 12'h000, conv_data;
	logic pready, pslverr, err, conv_clk, conv_start, conv_abort, conv_diff, conv_done, win_event;
	logic [4:0] conv_pos_sel, conv_neg_sel;
	logic [3:0] conv_gain;
	int error_cnt = 0, n_compared = 0, n_start = 0, n_abort = 0, n_ev = 0, cyc = 0;
	always #25 pclk = ~pclk;
	awtsc_top #(.CLK_DIV(2)) uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .conv_clk(conv_clk), .conv_start(conv_start),
		.conv_abort(conv_abort), .conv_pos_sel(conv_pos_sel), .conv_neg_sel(conv_neg_sel),
		.conv_diff(conv_diff), .conv_gain(conv_gain), .conv_done(conv_done),
		.conv_data(conv_data), .win_event(win_event));
	awtsc_core_model core (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
		.conv_abort(conv_abort), .lat(lat), .val(val), .conv_done(conv_done),
		.conv_data(conv_data));
	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout ends this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_done;
		int n;
		n = 0;
		while (conv_done !== 1'b1 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		if (n == 400) error_cnt++;
		repeat (4) @(posedge pclk);
	endtask
	// Waiting for the result also lets the start bit settle
	task automatic run_conv(input logic [11:0] v);
		val <= v;
		apb(1, OFS_SW_TRIG, 32'h2);
		wait_done();
	endtask
	function automatic logic exp_hit(input int m, input logic [11:0] r);
		case (m)
			1: return r > 12'h100;
			2: return r < 12'h300;
			3: return r > 12'h100 && r < 12'h300;
			4: return !(r > 12'h100 && r < 12'h300);
			default: return 1'b0;
		endcase
	endfunction
	// ==========================================================
	// Monitor and timeout
	always @(posedge pclk) begin
		cyc++;
		if (conv_start === 1'b1) n_start++;
		if (win_event === 1'b1) n_ev++;
		if (conv_abort === 1'b1) begin
			n_abort++;
			check(conv_clk, 0);
		end
		if (cyc == 40000) begin
			error_cnt++;
			give_verdict();
		end
	end
	task give_verdict;
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs;
		apb(0, OFS_WIN_CTRL, 0);
		check(rd, 0);
		apb(0, OFS_SW_TRIG, 0);
		check(rd, 0);
		apb(1, OFS_INPUT, 32'hFFFFFFFF);
		apb(0, OFS_INPUT, 0);
		check(rd, 32'h0FFF1F1F);
		apb(0, 8'h40, 0);
		check({rd[30:0], err}, 1);
	endtask
	// Boundary values test the strict comparisons
	task automatic t_window;
		logic [11:0] v;
		int e;
		apb(1, OFS_WIN_LOWER, 32'h100);
		apb(1, OFS_WIN_UPPER, 32'h300);
		for (int m = 0; m < 8; m++) begin
			for (int k = 1; k < 4; k++) begin
				v = 12'(k * 256);
				apb(1, OFS_WIN_CTRL, m);
				apb(1, OFS_CONTROL, 32'h8 | (m[0] << 1));
				e = n_ev;
				run_conv(v);
				apb(0, OFS_RESULT, 0);
				check(rd, m[0] ? {16'h0, v, 4'h0} : {20'h0, v});
				apb(0, OFS_STATUS, 0);
				check(rd[0], exp_hit(m, v));
				check(n_ev - e, exp_hit(m, v));
				apb(1, OFS_STATUS, 32'h1);
			end
			apb(0, OFS_WIN_CTRL, 0);
			check(rd, m);
		end
		apb(1, OFS_CONTROL, 0);
	endtask
	// Gain, negative, positive and differential at each launch
	task automatic t_select;
		logic [4:0] ng;
		logic [3:0] g;
		for (int i = 0; i < 16; i++) begin
			g = 4'(i);
			ng = (i < 8) ? 5'(i) : 5'(i + 16);
			apb(1, OFS_CONTROL, i & 1);
			apb(1, OFS_INPUT, {4'h0, g, 8'h00, 3'h0, ng, 3'h0, 5'(i)});
			run_conv(12'h123);
			check(conv_gain, (g <= 4'h4 || g == 4'hF) ? g : 4'h0);
			check(conv_neg_sel, (ng <= 5'h07 || ng == 5'h19) ? ng : 5'h18);
			check(conv_diff, i & 1);
			check(conv_pos_sel, i);
		end
		apb(1, OFS_CONTROL, 0);
	endtask
	task automatic t_scan;
		apb(1, OFS_INPUT, 32'h00120003); // Scan of inputs 4 to 6 stays on pins
		for (int k = 0; k < 4; k++) begin
			run_conv(12'h010);
			check(conv_pos_sel, 4 + (k % 3));
		end
		apb(1, OFS_INPUT, 32'h00100003);
		for (int k = 0; k < 2; k++) begin
			run_conv(12'h010);
			check(conv_pos_sel, 4);
		end
	endtask
	task automatic t_trigger;
		int s, a;
		s = n_start;
		lat <= 8'd40;
		apb(1, OFS_SW_TRIG, 32'h2);
		apb(1, OFS_SW_TRIG, 32'h2);
		apb(1, OFS_SW_TRIG, 32'h2);
		wait_done();
		wait_done();
		repeat (20) @(posedge pclk);
		check(n_start - s, 2);
		s = n_start;
		a = n_abort;
		apb(1, OFS_SW_TRIG, 32'h2);
		repeat (5) @(posedge pclk);
		apb(1, OFS_SW_TRIG, 32'h1);
		apb(0, OFS_SW_TRIG, 0);
		check(rd, 0);
		wait_done();
		check(n_abort - a, 1);
		check(n_start - s, 2);
		apb(1, OFS_SW_TRIG, 32'h0);
		repeat (10) @(posedge pclk);
		check(n_abort - a, 1);
		check(n_start - s, 2);
		lat <= 8'd30;
		apb(1, OFS_CONTROL, 32'h4);
		run_conv(12'h050);
		wait_done();
		wait_done();
		check(n_start - s, 6);
		apb(1, OFS_CONTROL, 0);
		wait_done();
		repeat (10) @(posedge pclk);
		check(n_start - s, 6);
		// Clock enable low must hold a pending start back
		s = n_start;
		apb(1, OFS_SW_TRIG, 32'h2);
		ce <= 1'b0;
		repeat (10) @(posedge pclk);
		check(n_start - s, 0);
		ce <= 1'b1;
		wait_done();
		check(n_start - s, 1);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_window();
		t_select();
		t_scan();
		t_trigger();
		give_verdict();
	end
endmodule
